// >>> verilog/rpt_params.svh
// constants for the pulse, trim, lock and test control block
`ifndef RPT_PARAMS_SVH
`define RPT_PARAMS_SVH
// register offsets
`define RPT_ADR_CTRL      8'h00
`define RPT_ADR_FLAGS     8'h01
`define RPT_ADR_SEL       8'h02
`define RPT_ADR_TRIM      8'h10
`define RPT_ADR_HOURS     8'h23
`define RPT_ADR_RAM_HI    4'h5
// main_control fields
`define RPT_B_TUNE        0
`define RPT_B_PULSE_EN    1
`define RPT_B_TIMER_EN    3
`define RPT_B_H12         4
`define RPT_B_LOCK        5
`define RPT_B_TEST0       6
`define RPT_B_TEST1       7
// flags_and_masks and pulse_and_sync_select fields
`define RPT_B_PULSE_MASK  0
`define RPT_B_PULSE_FLAG  4
`define RPT_B_INIT        4
// reset values
`define RPT_RST_BYTE      8'h00
// timing: oscillator rate, tick rate, speed-up, tuning duty
`define RPT_OSC_HZ        32768
`define RPT_TICK_HZ       100
`define RPT_FAST          32
`define RPT_TRIM_SEC      31
`define RPT_TUNE_PCT      20
`endif

// >>> verilog/rpt_pkg.sv
// types for the pulse, trim, lock and test control block
package rpt_pkg;
    typedef enum logic [1:0] {
        RPT_NORMAL,
        RPT_FAST32,
        RPT_PAR100,
        RPT_PAR3K2
    } rpt_test_type;
    // host bus pins as the host drives them
    typedef struct packed {
        logic       cs_n;
        logic       data_sel;
        logic       rd_n;
        logic       wr_n;
        logic [7:0] ad;
    } rpt_bus_type;
endpackage

// >>> verilog/rpt_core.sv
// pulse source, time-set lock, trimming, tuning and test control
`timescale 1ns/1ps
`include "rpt_params.svh"
module rpt_core #(
    parameter int TRIM_WIN_OSC = `RPT_OSC_HZ * `RPT_TRIM_SEC
) (
    input  wire logic              mclk_i,
    input  wire logic              srst_i,
    input  wire rpt_pkg::rpt_bus_type bus_i,
    input  wire logic              osc_i,
    input  wire logic              standby_i,
    output logic [7:0]             dat_o,
    output logic                   dat_oe_n_o,
    output logic                   irq_o,
    output logic                   irq_oe_n_o
);
    import rpt_pkg::*;

    localparam logic [16:0] OSC_FULL = 17'(`RPT_OSC_HZ);
    localparam logic [16:0] INC_SLOW = 17'(`RPT_TICK_HZ);
    localparam logic [16:0] INC_FAST = 17'(`RPT_TICK_HZ * `RPT_FAST);
    localparam logic [8:0]  TUNE_LOW =
        9'(`RPT_OSC_HZ * `RPT_TUNE_PCT / (100 * `RPT_TICK_HZ));

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    rpt_bus_type bus_s1_reg, bus_s2_reg, bus_d_reg;
    logic [1:0]  misc_s1_reg, misc_s2_reg;
    logic        osc_d_reg;
    // first stage feeds only the second stage
    always_ff @(posedge mclk_i) begin
        bus_s1_reg  <= bus_i;
        bus_s2_reg  <= bus_s1_reg;
        bus_d_reg   <= bus_s2_reg;
        misc_s1_reg <= {standby_i, osc_i};
        misc_s2_reg <= misc_s1_reg;
        osc_d_reg   <= misc_s2_reg[0];
    end
    logic standby, osc_edge, wr_go, wr_adr, wr_dat, rd_act;
    assign standby  = misc_s2_reg[1];
    assign osc_edge = misc_s2_reg[0] & ~osc_d_reg;
    // writes act once per strobe, on its synchronised falling edge; rd_act follows the strobe level
    assign wr_go  = ~bus_s2_reg.cs_n & ~bus_s2_reg.wr_n & bus_d_reg.wr_n;
    assign wr_adr = wr_go & ~bus_s2_reg.data_sel;
    assign wr_dat = wr_go & bus_s2_reg.data_sel;
    assign rd_act = ~bus_s2_reg.cs_n & ~bus_s2_reg.rd_n
                  & bus_s2_reg.data_sel;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] adr_reg, ctrl_reg, sel_reg, trim_reg;
    logic [3:0] mask_reg;
    logic       pflag_reg, tune_reg, tune_arm_reg;
    logic [7:0] ram_reg [16];
    logic       init_go, pulse_ev, lock, w_ctrl, w_flags, w_trim, w_hours;
    rpt_test_type test;
    assign test    = rpt_test_type'(ctrl_reg[`RPT_B_TEST1:`RPT_B_TEST0]);
    assign lock    = ctrl_reg[`RPT_B_LOCK];
    assign w_ctrl  = wr_dat & (adr_reg == `RPT_ADR_CTRL);
    assign w_flags = wr_dat & (adr_reg == `RPT_ADR_FLAGS);
    assign w_trim  = wr_dat & (adr_reg == `RPT_ADR_TRIM) & ~lock;
    assign w_hours = wr_dat & (adr_reg == `RPT_ADR_HOURS) & ~lock;
    // one then zero on the init bit
    assign init_go = wr_dat & (adr_reg == `RPT_ADR_SEL)
                   & sel_reg[`RPT_B_INIT] & ~bus_s2_reg.ad[`RPT_B_INIT];

    // address phase latches the pointer
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            adr_reg <= `RPT_RST_BYTE;
        end else if (wr_adr) begin
            adr_reg <= bus_s2_reg.ad;
        end
    end

    // control: init clears lock, format and test bits
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ctrl_reg <= `RPT_RST_BYTE;
            tune_reg <= 1'b0;
        end else if (init_go) begin
            ctrl_reg <= `RPT_RST_BYTE;
            tune_reg <= 1'b1;
        end else if (w_ctrl) begin
            ctrl_reg <= bus_s2_reg.ad;
            if (!bus_s2_reg.ad[`RPT_B_TUNE]) begin
                tune_reg <= 1'b0;
            end
        end
    end

    // select register; more than one pulse bit means off
    always_ff @(posedge mclk_i) begin
        if (srst_i || init_go) begin
            sel_reg <= `RPT_RST_BYTE;
        end else if (wr_dat && adr_reg == `RPT_ADR_SEL) begin
            sel_reg <= bus_s2_reg.ad;
        end
    end

    // pulse flag: a new pulse beats a clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (srst_i || init_go) begin
            pflag_reg <= 1'b0;
            mask_reg  <= 4'h0;
        end else begin
            if (pulse_ev) begin
                pflag_reg <= 1'b1;
            end else if (w_flags && !bus_s2_reg.ad[`RPT_B_PULSE_FLAG]) begin
                pflag_reg <= 1'b0;
            end
            if (w_flags) begin
                mask_reg <= bus_s2_reg.ad[3:0];
            end
        end
    end

    // trim value; tuning arms on a zero write
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            trim_reg     <= `RPT_RST_BYTE;
            tune_arm_reg <= 1'b0;
        end else begin
            if (w_trim) begin
                trim_reg <= bus_s2_reg.ad;
            end
            if (!tune_reg || init_go) begin
                tune_arm_reg <= 1'b0;
            end else if (w_trim && bus_s2_reg.ad == 8'h00) begin
                tune_arm_reg <= 1'b1;
            end
        end
    end

    // user RAM ignores the lock
    always_ff @(posedge mclk_i) begin
        if (wr_dat && adr_reg[7:4] == `RPT_ADR_RAM_HI) begin
            ram_reg[adr_reg[3:0]] <= bus_s2_reg.ad;
        end
    end

    // ----------------------------------------------------------------
    // divider chain with trimming
    // ----------------------------------------------------------------
    logic [19:0] win_reg;
    logic [7:0]  skip_reg;
    logic        keep;
    // swallowed edges never reach the divider
    assign keep = osc_edge & (skip_reg == 8'h00);
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            win_reg  <= 20'h0_0000;
            skip_reg <= 8'h00;
        end else if (osc_edge) begin
            if (win_reg == 20'(TRIM_WIN_OSC - 1)) begin
                win_reg  <= 20'h0_0000;
                skip_reg <= ctrl_reg[`RPT_B_TEST1] ? 8'h00 : trim_reg;
            end else begin
                win_reg <= win_reg + 20'h0_0001;
                if (skip_reg != 8'h00) begin
                    skip_reg <= ctrl_reg[`RPT_B_TEST1] ? 8'h00
                              : skip_reg - 8'h01;
                end
            end
        end
    end

    // fractional divide to the tick; faster in the RPT_FAST32 and RPT_PAR3K2 test modes
    logic [16:0] acc_reg, acc_sum;
    logic [8:0]  phase_reg;
    logic        tick;
    assign acc_sum = acc_reg + ((test == RPT_FAST32 || test == RPT_PAR3K2)
                   ? INC_FAST : INC_SLOW);
    assign tick = keep & (acc_sum >= OSC_FULL);
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            acc_reg   <= 17'h0_0000;
            phase_reg <= 9'h000;
        end else if (keep) begin
            acc_reg   <= tick ? acc_sum - OSC_FULL : acc_sum;
            phase_reg <= tick ? 9'h000
                       : (phase_reg == 9'h1FF ? phase_reg
                       : phase_reg + 9'h001);
        end
    end

    // ----------------------------------------------------------------
    // clock counters, 24-hour binary inside
    // ----------------------------------------------------------------
    logic [6:0] hund_reg, sec_reg, min_reg;
    logic [4:0] hour_reg;
    logic       par, h_wrap, s_wrap, m_wrap;
    assign par    = test == RPT_PAR100 || test == RPT_PAR3K2;
    assign h_wrap = hund_reg == 7'd99;
    assign s_wrap = sec_reg == 7'd59;
    assign m_wrap = min_reg == 7'd59;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            hund_reg <= 7'd0;
            sec_reg  <= 7'd0;
            min_reg  <= 7'd0;
            hour_reg <= 5'd0;
        end else if (w_hours) begin
            hour_reg <= to24(bus_s2_reg.ad, ctrl_reg[`RPT_B_H12]);
        end else if (tick && par) begin
            if (ctrl_reg[`RPT_B_TIMER_EN]) begin
                hund_reg <= h_wrap ? 7'd0 : hund_reg + 7'd1;
                sec_reg  <= s_wrap ? 7'd0 : sec_reg + 7'd1;
                min_reg  <= m_wrap ? 7'd0 : min_reg + 7'd1;
                hour_reg <= hour_reg == 5'd23 ? 5'd0 : hour_reg + 5'd1;
            end
        end else if (tick) begin
            hund_reg <= h_wrap ? 7'd0 : hund_reg + 7'd1;
            if (h_wrap) begin
                sec_reg <= s_wrap ? 7'd0 : sec_reg + 7'd1;
                if (s_wrap) begin
                    min_reg <= m_wrap ? 7'd0 : min_reg + 7'd1;
                    if (m_wrap) begin
                        hour_reg <= hour_reg == 5'd23 ? 5'd0
                                  : hour_reg + 5'd1;
                    end
                end
            end
        end
    end

    // host hours byte (BCD, 12h carries PM in bit 7) to 24h binary
    function automatic logic [4:0] to24(input logic [7:0] v,
                                        input logic h12);
        logic [4:0] b;
        b = 5'(v[5:4] * 4'd10) + 5'(v[3:0]);
        if (!h12) begin
            return b;
        end
        if (b == 5'd12) begin
            b = 5'd0;
        end
        return v[7] ? b + 5'd12 : b;
    endfunction

    // 24h binary to the host view in the chosen format
    function automatic logic [7:0] from24(input logic [4:0] h,
                                          input logic h12);
        logic [4:0] b;
        b = h;
        if (h12) begin
            b = (h >= 5'd12) ? h - 5'd12 : h;
            b = (b == 5'd0) ? 5'd12 : b;
        end
        return {h12 & (h >= 5'd12), 1'b0,
                (b >= 5'd20) ? 2'd2 : (b >= 5'd10) ? 2'd1 : 2'd0,
                4'((b >= 5'd20) ? b - 5'd20
                 : (b >= 5'd10) ? b - 5'd10 : b)};
    endfunction

    // ----------------------------------------------------------------
    // pulse source and interrupt pin
    // ----------------------------------------------------------------
    logic [3:0] psel;
    logic       onehot, pulse_on, irq_act, tune_low;
    assign psel     = sel_reg[3:0];
    assign onehot   = psel != 4'h0 && (psel & (psel - 4'h1)) == 4'h0;
    // enable bit stays untouched in standby, so pulses resume after it
    assign pulse_on = ctrl_reg[`RPT_B_PULSE_EN] & onehot & ~standby;
    assign pulse_ev = tick & pulse_on & ((psel[0])
                    | (psel[1] & (hund_reg % 7'd10 == 7'd9))
                    | (psel[2] & h_wrap)
                    | (psel[3] & h_wrap & s_wrap));
    assign tune_low = tune_arm_reg & (phase_reg < TUNE_LOW);
    // pulse cannot pull the pin during standby
    assign irq_act  = pflag_reg & mask_reg[`RPT_B_PULSE_MASK] & ~standby;

    // open drain: enable low pulls the pin low
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            irq_oe_n_o <= 1'b1;
            irq_o      <= 1'b0;
        end else begin
            irq_oe_n_o <= tune_arm_reg ? ~tune_low : ~irq_act;
            irq_o      <= 1'b0;
        end
    end

    // read path; reads of clock data never blocked by the lock
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dat_o      <= `RPT_RST_BYTE;
            dat_oe_n_o <= 1'b1;
        end else begin
            dat_oe_n_o <= ~rd_act;
            unique case (adr_reg)
                `RPT_ADR_CTRL:  dat_o <= {ctrl_reg[7:1], tune_reg};
                `RPT_ADR_FLAGS: dat_o <= {3'b000, pflag_reg, mask_reg};
                `RPT_ADR_SEL:   dat_o <= sel_reg;
                `RPT_ADR_TRIM:  dat_o <= trim_reg;
                `RPT_ADR_HOURS: dat_o <= from24(hour_reg,
                                    ctrl_reg[`RPT_B_H12]);
                default: dat_o <= (adr_reg[7:4] == `RPT_ADR_RAM_HI)
                                ? ram_reg[adr_reg[3:0]] : 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_pulse_flag;
        @(posedge mclk_i) disable iff (srst_i)
        pulse_ev |=> pflag_reg;
    endproperty
    a_pulse_flag: assert property (p_pulse_flag)
        else $error("pulse did not set flag");
    property p_multi_off;
        @(posedge mclk_i) disable iff (srst_i)
        !onehot |-> !pulse_ev;
    endproperty
    a_multi_off: assert property (p_multi_off)
        else $error("pulse with bad select");
    property p_standby;
        @(posedge mclk_i) disable iff (srst_i)
        standby |-> !pulse_ev && !irq_act;
    endproperty
    a_standby: assert property (p_standby)
        else $error("pulse active in standby");
    property p_irq_hold;
        @(posedge mclk_i) disable iff (srst_i)
        irq_act && !tune_arm_reg ##1 !tune_arm_reg |-> !irq_oe_n_o;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("irq not held for flag");
    property p_lock_trim;
        @(posedge mclk_i) disable iff (srst_i)
        lock && !$past(init_go) ##1 1'b1 |-> $stable(trim_reg);
    endproperty
    a_lock_trim: assert property (p_lock_trim)
        else $error("trim changed while locked");
    property p_init;
        @(posedge mclk_i) disable iff (srst_i)
        init_go |=> ctrl_reg == 8'h00 && tune_reg && !pflag_reg;
    endproperty
    a_init: assert property (p_init)
        else $error("init did not clear state");
    property p_test1_trim;
        @(posedge mclk_i) disable iff (srst_i)
        ctrl_reg[`RPT_B_TEST1] && osc_edge |=> skip_reg == 8'h00;
    endproperty
    a_test1_trim: assert property (p_test1_trim)
        else $error("trim active in test");
    property p_pm_bit;
        @(posedge mclk_i) disable iff (srst_i)
        rd_act && adr_reg == `RPT_ADR_HOURS && !ctrl_reg[`RPT_B_H12]
        && $stable(adr_reg) ##1 $stable(ctrl_reg) |-> !dat_o[7];
    endproperty
    a_pm_bit: assert property (p_pm_bit)
        else $error("pm bit set in 24h");
    c_pulse: cover property (@(posedge mclk_i) pulse_ev ##[1:20] w_flags);
    c_tune: cover property (@(posedge mclk_i) tune_arm_reg && tune_low);
    c_lock: cover property (@(posedge mclk_i) lock && wr_dat
                            && adr_reg == `RPT_ADR_TRIM);
endmodule

// >>> tb/rpt_host.sv
// host processor model that drives the multiplexed register bus
`timescale 1ns/1ps
module rpt_host (
    input  wire logic                 mclk_i,
    output rpt_pkg::rpt_bus_type      bus_o
);
    import rpt_pkg::*;
    // strobe and gap length, kept above the four-cycle minimum
    localparam int STB_CYC = 6;
    // wait after the interrupt falls before acknowledging, 60 us at 50 ns
    localparam int ACK_GAP = 1200;

    // idle bus: no strobes, address/data holds a non-zero filler
    initial begin
        bus_o = '{cs_n: 1'b1, data_sel: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
                  ad: 8'h5a};
    end

    // ------------------------------------------------------------
    // bus phases
    // ------------------------------------------------------------
    // one strobe; all qualifiers held for the whole low time, then the
    // data lines flip so a stale value never passes for a live one
    task automatic phase(input logic sel, input logic wr,
                         input logic [7:0] val);
        @(negedge mclk_i);
        bus_o.cs_n = 1'b0;
        bus_o.data_sel = sel;
        bus_o.ad = val;
        bus_o.wr_n = ~wr;
        bus_o.rd_n = wr;
        repeat (STB_CYC) @(negedge mclk_i);
        bus_o.cs_n = 1'b1;
        bus_o.wr_n = 1'b1;
        bus_o.rd_n = 1'b1;
        bus_o.ad = ~val;
        repeat (STB_CYC - 1) @(negedge mclk_i);
    endtask

    // address phase first, then the data write
    task automatic wr_reg(input logic [7:0] adr, input logic [7:0] dat);
        phase(1'b0, 1'b1, adr);
        phase(1'b1, 1'b1, dat);
    endtask

    // address phase first, then the data read; bench checks the byte
    task automatic rd_reg(input logic [7:0] adr);
        phase(1'b0, 1'b1, adr);
        phase(1'b1, 1'b0, ~adr);
    endtask

    // hold off the flag clear after the interrupt falls
    task automatic hold_before_ack();
        repeat (ACK_GAP) @(negedge mclk_i);
    endtask
endmodule

// >>> tb/rtc_pulse_trim_lock_test_test.sv
// self-checking bench for the pulse, lock, trim and tuning control block
`timescale 1ns/1ps
`include "rpt_params.svh"
module rtc_pulse_trim_lock_test_test;
    import rpt_pkg::*;
    localparam int TRIM_WIN = 64;
    // one 100 Hz tick is about 1968 cycles with the oscillator at 6 cycles;
    // a small trim in the 64-edge window stretches it to about 2030
    localparam int TICK_MAX = 2600;
    logic        mclk_i;
    logic        srst_i;
    logic        osc_i;
    logic        standby_i;
    rpt_bus_type bus_i;
    logic [7:0]  dat_o;
    logic        dat_oe_n_o;
    logic        irq_o;
    logic        irq_oe_n_o;
    int          n_mismatch;
    int          checks_done;
    int          seed;
    int          n;
    int          lo_cnt;
    logic [7:0]  exp_q[$];
    logic [7:0]  rnd;
    logic        rd_taken;

    rpt_core #(.TRIM_WIN_OSC(TRIM_WIN)) dut (
        .mclk_i(mclk_i), .srst_i(srst_i), .bus_i(bus_i), .osc_i(osc_i),
        .standby_i(standby_i), .dat_o(dat_o), .dat_oe_n_o(dat_oe_n_o),
        .irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o));
    rpt_host host (.mclk_i(mclk_i), .bus_o(bus_i));

    // ------------------------------------------------------------
    // clocks
    // ------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    // oscillator sped up so a tick fits the run; toggles off the edge
    initial begin
        osc_i = 1'b0;
        forever begin
            repeat (3) @(negedge mclk_i);
            osc_i = ~osc_i;
        end
    end

    // ------------------------------------------------------------
    // compare and close
    // ------------------------------------------------------------
    task automatic chk_byte(input string what, input logic [7:0] exp,
                            input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp,
                           input logic got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // read with the expected byte noted for the monitor
    task automatic rd_exp(input logic [7:0] adr, input logic [7:0] exp);
        exp_q.push_back(exp);
        host.rd_reg(adr);
    endtask
    // bounded wait for the interrupt pin to reach a level
    task automatic wait_irq(input logic lvl, input int max);
        n = 0;
        while (irq_oe_n_o !== lvl && n < max) begin
            @(negedge mclk_i);
            n++;
        end
        chk_bit("irq level reached", lvl, irq_oe_n_o);
    endtask
    // cycles the interrupt is active over a window
    task automatic count_low(input int cyc, output int lows);
        lows = 0;
        repeat (cyc) begin
            @(negedge mclk_i);
            if (irq_oe_n_o !== 1'b1)
                lows++;
        end
    endtask

    // monitor: first settled cycle of each read drive takes the oldest note
    always @(negedge mclk_i) begin
        if (dat_oe_n_o === 1'b0 && !rd_taken) begin
            rd_taken = 1'b1;
            if (exp_q.size() > 0)
                chk_byte("read data", exp_q.pop_front(), dat_o);
            else
                chk_byte("unrequested read", 8'h00, 8'hxx);
        end else if (dat_oe_n_o === 1'b1) begin
            rd_taken = 1'b0;
        end
    end

    // watchdog, well beyond the roughly 21000 cycles the tests need
    initial begin
        repeat (80000) @(negedge mclk_i);
        n_mismatch++;
        $display("MISMATCH watchdog expected done seen hang");
        end_of_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 1;
        n_mismatch = 0;
        checks_done = 0;
        rd_taken = 1'b0;
        srst_i = 1'b1;
        standby_i = 1'b0;
        repeat (10) @(negedge mclk_i);
        srst_i = 1'b0;
        chk_bit("irq idle after reset", 1'b1, irq_oe_n_o);
        rd_exp(`RPT_ADR_CTRL, `RPT_RST_BYTE);
        rd_exp(`RPT_ADR_FLAGS, `RPT_RST_BYTE);
        rd_exp(`RPT_ADR_TRIM, `RPT_RST_BYTE);
        // full-range trim, then lock refuses trim and hours but not ram
        host.wr_reg(`RPT_ADR_TRIM, 8'hff);
        rd_exp(`RPT_ADR_TRIM, 8'hff);
        host.wr_reg(`RPT_ADR_HOURS, 8'h13);
        rd_exp(`RPT_ADR_HOURS, 8'h13);
        host.wr_reg(`RPT_ADR_CTRL, 8'h10);
        rd_exp(`RPT_ADR_HOURS, 8'h81);
        host.wr_reg(`RPT_ADR_CTRL, 8'h30);
        host.wr_reg(`RPT_ADR_TRIM, 8'h55);
        rd_exp(`RPT_ADR_TRIM, 8'hff);
        host.wr_reg(`RPT_ADR_HOURS, 8'h05);
        rd_exp(`RPT_ADR_HOURS, 8'h81);
        rnd = 8'($random(seed));
        host.wr_reg(8'h5a, rnd);
        rd_exp(8'h5a, rnd);
        host.wr_reg(`RPT_ADR_CTRL, 8'h00);
        rd_exp(`RPT_ADR_HOURS, 8'h13);
        host.wr_reg(`RPT_ADR_TRIM, 8'h02);
        rd_exp(`RPT_ADR_TRIM, 8'h02);
        // 10 ms pulse, masked onto the pin, held until acknowledged
        host.wr_reg(`RPT_ADR_FLAGS, 8'h01);
        host.wr_reg(`RPT_ADR_SEL, 8'h01);
        host.wr_reg(`RPT_ADR_CTRL, 8'h02);
        wait_irq(1'b0, TICK_MAX);
        rd_exp(`RPT_ADR_FLAGS, 8'h11);
        host.hold_before_ack();
        chk_bit("irq held", 1'b0, irq_oe_n_o);
        host.wr_reg(`RPT_ADR_FLAGS, 8'h01);
        repeat (2) @(negedge mclk_i);
        chk_bit("irq after ack", 1'b1, irq_oe_n_o);
        // mask off: flag still sets but the pin stays quiet
        host.wr_reg(`RPT_ADR_FLAGS, 8'h00);
        count_low(TICK_MAX, lo_cnt);
        chk_byte("masked irq lows", 8'h00, 8'(lo_cnt));
        rd_exp(`RPT_ADR_FLAGS, 8'h10);
        // two interval bits set disables the source
        host.wr_reg(`RPT_ADR_SEL, 8'h03);
        host.wr_reg(`RPT_ADR_FLAGS, 8'h01);
        count_low(TICK_MAX, lo_cnt);
        chk_byte("multi select lows", 8'h00, 8'(lo_cnt));
        // standby suspends the source, power return resumes it
        standby_i = 1'b1;
        host.wr_reg(`RPT_ADR_SEL, 8'h01);
        count_low(TICK_MAX, lo_cnt);
        chk_byte("standby lows", 8'h00, 8'(lo_cnt));
        standby_i = 1'b0;
        wait_irq(1'b0, TICK_MAX);
        // init then trim zero: 100 Hz at 20 percent on the pin
        host.wr_reg(`RPT_ADR_SEL, 8'h10);
        host.wr_reg(`RPT_ADR_SEL, 8'h00);
        rd_exp(`RPT_ADR_CTRL, 8'h01);
        host.wr_reg(`RPT_ADR_TRIM, 8'h00);
        wait_irq(1'b1, TICK_MAX);
        wait_irq(1'b0, TICK_MAX);
        wait_irq(1'b1, 500);
        lo_cnt = n;
        wait_irq(1'b0, TICK_MAX);
        chk_bit("tune low width", 1'b1, lo_cnt inside {[380:400]});
        chk_bit("tune period", 1'b1, (lo_cnt + n) inside {[1950:1980]});
        host.wr_reg(`RPT_ADR_CTRL, 8'h00);
        count_low(TICK_MAX, lo_cnt);
        chk_byte("after tune lows", 8'h00, 8'(lo_cnt));
        rd_exp(`RPT_ADR_CTRL, 8'h00);
        // fast test mode: the 10 ms pulse comes 32 times sooner
        host.wr_reg(`RPT_ADR_FLAGS, 8'h01);
        host.wr_reg(`RPT_ADR_SEL, 8'h01);
        host.wr_reg(`RPT_ADR_CTRL, 8'h42);
        wait_irq(1'b0, 150);
        // leaving test needs both test bits cleared by software
        host.wr_reg(`RPT_ADR_CTRL, 8'h00);
        host.wr_reg(`RPT_ADR_FLAGS, 8'h00);
        repeat (2) @(negedge mclk_i);
        chk_bit("irq after test", 1'b1, irq_oe_n_o);
        chk_byte("reads left", 8'h00, 8'(exp_q.size()));
        end_of_test();
    end
endmodule
